//--- verilog/vhif_top.sv
`include "vhif_map.svh"

// Byte FIFO with valid/ready on both sides
module vhif_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    // Refused at elaboration: pointer wrap needs a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_cfg
        $error("vhif_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [LW-1:0] cnt_ff;
    logic push;
    logic pop;

    // Honest flags straight from the count
    assign in_ready = (cnt_ff != LW'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem[rd_ptr_ff];
    assign level = cnt_ff;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage has no reset; only pointers and count need a defined value
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule : vhif_fifo

// Host status, interrupt and FIFO port of the VBI slicer
module vhif_top import vhif_pkg::*; #(
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Slicer line stream
    input wire logic SLC_SOL,
    input wire logic [7:0] SLC_LEN,
    input wire logic [2:0] SLC_TYPE,
    input wire logic SLC_VALID,
    input wire logic [7:0] SLC_DATA,
    output logic SLC_READY,
    // Event pulses from the slicer and decoder
    input wire logic [6:0] EVT_DATA,
    input wire logic EVT_CPROT,
    input wire logic EVT_STD,
    // Video output path for FIFO data
    output logic VID_VALID,
    input wire logic VID_READY,
    output logic [7:0] VID_DATA,
    // Internal bus address and interrupt
    output logic [23:0] IBUS_ADDR,
    output logic HOST_IRQ
);
    localparam int LW = $clog2(DEPTH+1);

    // Refused at elaboration: line lengths are only eight bits wide
    if (DEPTH > 255) begin : g_bad_depth
        $error("vhif_top: DEPTH must fit an 8-bit line length");
    end

    logic [7:0] thr_ff;
    logic host_en_ff;
    logic [7:0] route_ff;
    logic [23:0] addr_ff;
    logic [7:0] raw0_ff;
    logic [2:0] raw1_ff;
    logic [7:0] en0_ff;
    logic [2:0] en1_ff;
    logic [7:0] rdata_ff;
    vhif_line_t line_ff;
    logic [7:0] left_ff;
    logic [LW-1:0] level;
    logic f_out_valid;
    logic f_out_ready;
    logic [7:0] f_out_data;
    logic f_in_ready;
    logic f_in_valid;
    logic [7:0] st0;
    logic [2:0] st1;
    logic wr0;
    logic wr1;
    logic sol_ok;
    logic fits;
    logic to_fifo;
    logic host_pop;
    logic thr_evt;
    logic full_evt;
    logic [7:0] nxt_rdata;
    logic [7:0] words;

    vhif_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(SLC_DATA),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data),
        .level(level)
    );

    // Host reads pop only while host access is on; otherwise video drains
    assign host_pop = REG_RD && (REG_ADDR == `VHIF_A_FIFO) && host_en_ff && f_out_valid;
    assign f_out_ready = host_en_ff ? host_pop : VID_READY;
    assign VID_VALID = f_out_valid && !host_en_ff;
    assign VID_DATA = f_out_data;

    // Line admission: teletext whatever its route bit, others by route bit; both must fit
    assign to_fifo = (SLC_TYPE == VHIF_TELETEXT) || route_ff[SLC_TYPE];
    // Whole-line fit check; a short line after a drop still enters
    assign fits = ({1'b0, SLC_LEN} <= 9'(DEPTH - int'(level)));
    assign sol_ok = SLC_SOL && (line_ff == VHIF_LN_IDLE) && (SLC_LEN != 8'h00);
    assign full_evt = sol_ok && to_fifo && !fits;
    assign f_in_valid = SLC_VALID && (line_ff == VHIF_LN_PASS);
    // Dropped bytes are swallowed so the slicer never stalls on them
    assign SLC_READY = (line_ff == VHIF_LN_PASS) ? f_in_ready : (line_ff == VHIF_LN_DROP);

    // Line state and remaining byte count
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            line_ff <= VHIF_LN_IDLE;
            left_ff <= 8'h00;
        end else begin
            case (line_ff)
                VHIF_LN_IDLE: begin
                    if (sol_ok) begin
                        line_ff <= (to_fifo && fits) ? VHIF_LN_PASS : VHIF_LN_DROP;
                        left_ff <= SLC_LEN;
                    end
                end
                VHIF_LN_PASS, VHIF_LN_DROP: begin
                    if (SLC_VALID && SLC_READY) begin
                        left_ff <= left_ff - 8'h01;
                        if (left_ff == 8'h01) begin
                            line_ff <= VHIF_LN_IDLE;
                        end
                    end
                end
                default: begin
                    line_ff <= VHIF_LN_IDLE;
                end
            endcase
        end
    end

    // Words are byte pairs; event fires while the count exceeds threshold
    assign words = 8'(level >> 1);
    assign thr_evt = (words > thr_ff);

    assign wr0 = REG_WR && (REG_ADDR == `VHIF_A_CLR0);
    assign wr1 = REG_WR && (REG_ADDR == `VHIF_A_CLR1);

    // Sticky raw flags: a new event beats a clear in the same cycle
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            raw0_ff <= `VHIF_ZERO8;
            raw1_ff <= 3'h0;
        end else begin
            raw0_ff <= (raw0_ff & ~(wr0 ? REG_WDATA : 8'h00)) | {thr_evt, EVT_DATA};
            raw1_ff <= (raw1_ff & ~(wr1 ? REG_WDATA[2:0] : 3'h0))
                | {EVT_CPROT, EVT_STD, full_evt};
        end
    end

    // Masking never touches the raw flags
    assign st0 = raw0_ff & en0_ff;
    assign st1 = raw1_ff & en1_ff;
    assign HOST_IRQ = (|st0) || (|st1);

    // Software-written control registers
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            thr_ff <= `VHIF_THR_RST;
            host_en_ff <= 1'b0;
            route_ff <= `VHIF_ROUTE_RST;
            addr_ff <= 24'h000000;
            en0_ff <= `VHIF_ZERO8;
            en1_ff <= 3'h0;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `VHIF_A_THR: thr_ff <= REG_WDATA;
                `VHIF_A_OUTCTL: host_en_ff <= REG_WDATA[`VHIF_B_HOST_EN];
                `VHIF_A_ROUTE: route_ff <= REG_WDATA;
                `VHIF_A_ADR0: addr_ff[7:0] <= REG_WDATA;
                `VHIF_A_ADR1: addr_ff[15:8] <= REG_WDATA;
                `VHIF_A_ADR2: addr_ff[23:16] <= REG_WDATA;
                `VHIF_A_EN0: en0_ff <= REG_WDATA;
                `VHIF_A_EN1: en1_ff <= REG_WDATA[2:0];
                default: begin
                end
            endcase
        end
    end
    assign IBUS_ADDR = addr_ff;

    // Read mux; reads have no side effect on flags
    always_comb begin
        nxt_rdata = 8'h00;
        case (REG_ADDR)
            `VHIF_A_WCNT: nxt_rdata = words;
            `VHIF_A_THR: nxt_rdata = thr_ff;
            `VHIF_A_OUTCTL: nxt_rdata = {7'h00, host_en_ff};
            `VHIF_A_ROUTE: nxt_rdata = route_ff;
            `VHIF_A_FIFO: nxt_rdata = host_pop ? f_out_data : 8'h00;
            `VHIF_A_ADR0: nxt_rdata = addr_ff[7:0];
            `VHIF_A_ADR1: nxt_rdata = addr_ff[15:8];
            `VHIF_A_ADR2: nxt_rdata = addr_ff[23:16];
            `VHIF_A_RAW0: nxt_rdata = raw0_ff;
            `VHIF_A_RAW1: nxt_rdata = {5'h00, raw1_ff};
            `VHIF_A_MSK_ST0: nxt_rdata = st0;
            `VHIF_A_MSK_ST1: nxt_rdata = {5'h00, st1};
            `VHIF_A_EN0: nxt_rdata = en0_ff;
            `VHIF_A_EN1: nxt_rdata = {5'h00, en1_ff};
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= REG_RD ? nxt_rdata : 8'h00;
        end
    end
    assign REG_RDATA = rdata_ff;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    sequence s_pop;
        REG_RD && REG_ADDR == `VHIF_A_FIFO && host_en_ff && f_out_valid;
    endsequence

    property p_pop_data;
        logic [7:0] d;
        (s_pop, d = f_out_data) |=> REG_RDATA == d
            && level == $past(level) - LW'(1) + LW'($past(f_in_valid && f_in_ready));
    endproperty
    a_pop_data: assert property (p_pop_data) else $error("FIFO read byte or pop wrong");

    property p_teletext_fifo;
        sol_ok && SLC_TYPE == VHIF_TELETEXT && fits |=> line_ff == VHIF_LN_PASS;
    endproperty
    a_teletext_fifo: assert property (p_teletext_fifo) else $error("Teletext line not sent to FIFO");

    property p_addr;
        REG_WR && REG_ADDR == `VHIF_A_ADR2 |=> IBUS_ADDR[23:16] == $past(REG_WDATA);
    endproperty
    a_addr: assert property (p_addr) else $error("Address high byte not stored");

    property p_drop;
        full_evt |=> raw1_ff[0] && line_ff == VHIF_LN_DROP ##1 !f_in_valid;
    endproperty
    a_drop: assert property (p_drop) else $error("Overflowing line not dropped");

    property p_fit;
        sol_ok && to_fifo && fits |=> line_ff == VHIF_LN_PASS;
    endproperty
    a_fit: assert property (p_fit) else $error("Fitting line refused");

    property p_irq;
        ##1 HOST_IRQ == (|(raw0_ff & en0_ff) || |(raw1_ff & en1_ff));
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt pin mismatch");

    property p_read_keeps;
        REG_RD && !REG_WR |=> raw0_ff == ($past(raw0_ff) | $past({thr_evt, EVT_DATA}));
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("Read cleared a flag");

    property p_sticky;
        EVT_STD |=> raw1_ff[1] [*1] ##0 (!$past(wr1) || raw1_ff[1]);
    endproperty
    a_sticky: assert property (p_sticky) else $error("Event pulse lost");

    property p_clear;
        wr1 && REG_WDATA[0] && !full_evt |=> !raw1_ff[0];
    endproperty
    a_clear: assert property (p_clear) else $error("Clear did not clear flag");

    property p_thr;
        words > thr_ff |=> raw0_ff[`VHIF_B_LEVEL_PASSED];
    endproperty
    a_thr: assert property (p_thr) else $error("Threshold event missed");

    property p_read_keeps_high;
        REG_RD && !REG_WR |=> raw1_ff == ($past(raw1_ff) | $past({EVT_CPROT, EVT_STD, full_evt}));
    endproperty
    a_read_keeps_high: assert property (p_read_keeps_high) else $error("Read cleared a high flag");

    property p_raw_unmasked;
        EVT_DATA[6] && !en0_ff[6] |=> raw0_ff[6];
    endproperty
    a_raw_unmasked: assert property (p_raw_unmasked) else $error("Raw flag hidden by mask");

    property p_clear_keeps;
        wr0 |=> (raw0_ff & ~$past(REG_WDATA))
            == (($past(raw0_ff) | $past({thr_evt, EVT_DATA})) & ~$past(REG_WDATA));
    endproperty
    a_clear_keeps: assert property (p_clear_keeps) else $error("Zero clear bit disturbed a flag");

    property p_video_drain;
        !host_en_ff && f_out_valid && VID_READY
            |=> level == $past(level) - LW'(1) + LW'($past(f_in_valid && f_in_ready));
    endproperty
    a_video_drain: assert property (p_video_drain) else $error("Video side did not drain");

    property p_host_off_read;
        REG_RD && REG_ADDR == `VHIF_A_FIFO && !host_en_ff |=> REG_RDATA == 8'h00;
    endproperty
    a_host_off_read: assert property (p_host_off_read) else $error("Host read FIFO while access off");

    sequence s_drop_line;
        line_ff == VHIF_LN_DROP;
    endsequence

    property p_drop_none;
        s_drop_line |=> level <= $past(level);
    endproperty
    a_drop_none: assert property (p_drop_none) else $error("Dropped line reached the FIFO");

    property p_rdata_idle;
        !REG_RD |=> REG_RDATA == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside its cycle");

    property p_mask1_write;
        REG_WR && REG_ADDR == `VHIF_A_EN1 |=> en1_ff == $past(REG_WDATA[2:0]);
    endproperty
    a_mask1_write: assert property (p_mask1_write) else $error("Mask 1 write not stored");
endmodule : vhif_top

//--- verilog/vhif_map.svh
`ifndef VHIF_MAP_SVH
`define VHIF_MAP_SVH
`define VHIF_A_WCNT 8'hbc
`define VHIF_A_THR 8'hbd
`define VHIF_A_OUTCTL 8'hc0
`define VHIF_A_ROUTE 8'hc4
`define VHIF_A_FIFO 8'he2
`define VHIF_A_ADR0 8'he8
`define VHIF_A_ADR1 8'he9
`define VHIF_A_ADR2 8'hea
`define VHIF_A_RAW0 8'hf0
`define VHIF_A_RAW1 8'hf1
`define VHIF_A_MSK_ST0 8'hf2
`define VHIF_A_MSK_ST1 8'hf3
`define VHIF_A_EN0 8'hf4
`define VHIF_A_EN1 8'hf5
`define VHIF_A_CLR0 8'hf6
`define VHIF_A_CLR1 8'hf7
`define VHIF_THR_RST 8'h80
`define VHIF_ZERO8 8'h00
`define VHIF_ROUTE_RST 8'hfe
`define VHIF_B_HOST_EN 0
`define VHIF_B_LEVEL_PASSED 7
`define VHIF_W_RAW1 3
`endif

//--- verilog/vhif_pkg.sv
package vhif_pkg;
    // Kind of VBI data carried by the line now arriving
    typedef enum logic [2:0] {
        VHIF_TELETEXT = 3'h0, VHIF_WSS = 3'h1, VHIF_VPS = 3'h2, VHIF_VITC = 3'h3,
        VHIF_CAPTION = 3'h4, VHIF_OTHER = 3'h5
    } vhif_type_t;
    // Line acceptance state
    typedef enum logic [1:0] {
        VHIF_LN_IDLE = 2'b00, VHIF_LN_PASS = 2'b01, VHIF_LN_DROP = 2'b10
    } vhif_line_t;
endpackage : vhif_pkg

//--- sim/vhif_host_model.sv
// Host processor on the register port; every strobe lasts one cycle
module vhif_host_model (
    // Clock
    input wire logic clk,
    // Register port toward the device
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bus idle from time zero
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // Single write cycle; returns once the written register has settled
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // Read strobe, then data taken in the following cycle only
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // Whole address before any indirect access, low byte first
    task automatic set_addr(input logic [23:0] a);
        wr_reg(8'he8, a[7:0]);
        wr_reg(8'he9, a[15:8]);
        wr_reg(8'hea, a[23:16]);
    endtask : set_addr

    // Host access must be on before the FIFO is drained here
    task automatic host_on();
        wr_reg(8'hc0, 8'h01);
    endtask : host_on
endmodule : vhif_host_model

//--- sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} vhif_row_t;
    logic ref_clk = 1'b0;
    logic arst_n, reg_wr, reg_rd, sol, valid, ready, cprot, std, vid_valid, vid_ready, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, len, sdata, vid_data, d;
    logic [2:0] ty;
    logic [6:0] evt;
    logic [23:0] ibus;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    // Write, read back, expect
    vhif_row_t rows [9] = '{'{8'he9, 8'h34, 8'h34}, '{8'hf4, 8'ha5, 8'ha5}, '{8'hf5, 8'h07, 8'h07},
        '{8'hf0, 8'hff, 8'h00}, '{8'hf1, 8'hff, 8'h00}, '{8'he5, 8'hff, 8'h00}, '{8'hf6, 8'hff, 8'h00},
        '{8'hf4, 8'h00, 8'h00}, '{8'hbd, 8'h33, 8'h33}};
    logic [7:0] zr [6] = '{8'he8, 8'he9, 8'hea, 8'hf4, 8'hf5, 8'hc0};

    vhif_top #(.DEPTH(8)) u_dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SLC_SOL(sol),
        .SLC_LEN(len), .SLC_TYPE(ty), .SLC_VALID(valid), .SLC_DATA(sdata), .SLC_READY(ready),
        .EVT_DATA(evt), .EVT_CPROT(cprot), .EVT_STD(std), .VID_VALID(vid_valid), .VID_READY(vid_ready),
        .VID_DATA(vid_data), .IBUS_ADDR(ibus), .HOST_IRQ(irq));
    vhif_host_model u_host (.clk(ref_clk), .addr(reg_addr), .wdata(reg_wdata), .wr(reg_wr), .rd(reg_rd),
        .rdata(reg_rdata));

    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    task automatic chk(input string n, input logic [23:0] g, input logic [23:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd_reg(a, d);
        chk($sformatf("reg %h", a), {16'h0000, d}, {16'h0000, e});
    endtask : rchk

    // One slicer line: start pulse, then every byte waits for ready
    task automatic line(input logic [7:0] n, input logic [2:0] t, input logic [7:0] b);
        @(posedge ref_clk);
        sol <= 1'b1;
        len <= n;
        ty <= t;
        @(posedge ref_clk);
        sol <= 1'b0;
        for (int i = 0; i < n; i++) begin
            valid <= 1'b1;
            sdata <= b + 8'(i);
            @(posedge ref_clk);
            while (ready !== 1'b1) @(posedge ref_clk);
        end
        valid <= 1'b0;
    endtask : line

    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        {arst_n, sol, valid, cprot, std, vid_ready} = 6'h00;
        {len, sdata, evt, ty} = 26'h0;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            u_host.wr_reg(rows[i].a, rows[i].w);
            rchk(rows[i].a, rows[i].e);
        end
        u_host.set_addr(24'habcdef);
        chk("ibus", ibus, 24'habcdef);
        // Second reset in mid-run brings back the defaults
        @(posedge ref_clk) arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        foreach (zr[i]) rchk(zr[i], 8'h00);
        rchk(8'hbd, 8'h80);
        rchk(8'hc4, 8'hfe);
        @(posedge ref_clk) #1 chk("rdata idle", {16'h0000, reg_rdata}, 24'h0);
        chk("ibus", ibus, 24'h000000);
        // Every external event input pulses once
        @(posedge ref_clk) {evt, cprot, std} <= 9'h1ff;
        @(posedge ref_clk) {evt, cprot, std} <= 9'h000;
        rchk(8'hf0, 8'h7f);
        rchk(8'hf1, 8'h06);
        rchk(8'hf2, 8'h00);
        rchk(8'hf0, 8'h7f);
        chk("irq", {23'h0, irq}, 24'h0);
        u_host.wr_reg(8'hf4, 8'h05);
        u_host.wr_reg(8'hf5, 8'h04);
        rchk(8'hf2, 8'h05);
        rchk(8'hf3, 8'h04);
        chk("irq", {23'h0, irq}, 24'h1);
        u_host.wr_reg(8'hf6, 8'h01);
        u_host.wr_reg(8'hf7, 8'h04);
        rchk(8'hf0, 8'h7e);
        rchk(8'hf1, 8'h02);
        rchk(8'hf3, 8'h00);
        chk("irq", {23'h0, irq}, 24'h1);
        u_host.wr_reg(8'hf6, 8'hff);
        u_host.wr_reg(8'hf7, 8'hff);
        rchk(8'hf0, 8'h00);
        chk("irq", {23'h0, irq}, 24'h0);
        // Fill: 6 bytes fit, 4 do not, 2 still fit while full flag stands
        u_host.wr_reg(8'hbd, 8'h02);
        line(8'd6, 3'h0, 8'h10);
        line(8'd4, 3'h0, 8'h20);
        line(8'd2, 3'h4, 8'h30);
        rchk(8'hbc, 8'h04);
        rchk(8'hf1, 8'h01);
        rchk(8'hf0, 8'h80);
        chk("vid", {15'h0, vid_valid, vid_data}, 24'h110);
        u_host.host_on();
        chk("vid valid", {23'h0, vid_valid}, 24'h0);
        for (int i = 0; i < 8; i++) rchk(8'he2, (i < 6) ? 8'(8'h10 + i) : 8'(8'h2a + i));
        rchk(8'he2, 8'h00);
        // Routing off: captions dropped, teletext still queued
        u_host.wr_reg(8'hc4, 8'h00);
        line(8'd2, 3'h0, 8'h40);
        line(8'd2, 3'h4, 8'h50);
        rchk(8'hbc, 8'h01);
        rchk(8'he2, 8'h40);
        rchk(8'he2, 8'h41);
        // Host access off: FIFO drains to the video side
        u_host.wr_reg(8'hc0, 8'h00);
        line(8'd2, 3'h0, 8'h60);
        rchk(8'he2, 8'h00);
        chk("vid", {15'h0, vid_valid, vid_data}, 24'h160);
        @(posedge ref_clk) vid_ready <= 1'b1;
        while (vid_valid === 1'b1) @(posedge ref_clk);
        rchk(8'hbc, 8'h00);
        complete_run();
    end
endmodule : testbench
